// *** verilog/lcdc_pkg.sv ***
package lcdc_pkg;

	localparam int         DATA_W      = 8;
	localparam int         ADDR_W      = 9;
	localparam int         MEM_BYTES   = 512;
	localparam int         NUM_SEG     = 64;
	localparam int         FIFO_DEPTH  = 8;
	localparam int         FIFO_W      = ADDR_W + DATA_W;
	localparam logic [5:0] LAST_COL    = 6'h3f;
	localparam logic [5:0] START_RST   = 6'h00;
	localparam logic       ON_RST      = 1'b0;
	localparam logic [1:0] BUSY_TICKS  = 2'h2;

	localparam logic [7:0] OP_ONOFF_M  = 8'hfe;
	localparam logic [7:0] OP_ONOFF    = 8'h3e;
	localparam logic [7:0] OP_START_M  = 8'hc0;
	localparam logic [7:0] OP_START    = 8'hc0;
	localparam logic [7:0] OP_PAGE_M   = 8'hf8;
	localparam logic [7:0] OP_PAGE     = 8'hb8;
	localparam logic [7:0] OP_YADDR_M  = 8'hc0;
	localparam logic [7:0] OP_YADDR    = 8'h40;

	localparam int         ST_BUSY     = 7;
	localparam int         ST_OFF      = 5;

	typedef enum logic [1:0] {
		LVL_SEL_A    = 2'h0,
		LVL_SEL_B    = 2'h1,
		LVL_NONSEL_A = 2'h2,
		LVL_NONSEL_B = 2'h3
	} lcdc_level_t;

	typedef struct packed {
		logic       select_a_n;
		logic       select_b_n;
		logic       select_c;
		logic       strobe;
		logic       read_nwrite;
		logic       data_sel;
		logic [7:0] data;
	} lcdc_host_t;

	typedef struct packed {
		lcdc_host_t host;
		logic       column_order;
		logic       frame_sync;
		logic       line_latch_clock;
		logic       polarity;
		logic       phase_1;
		logic       phase_2;
	} lcdc_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} lcdc_wr_t;

	typedef lcdc_level_t [NUM_SEG-1:0] lcdc_seg_t;

endpackage

// *** verilog/lcdc_column_driver.sv ***
`timescale 1ns/1ps

// =====================================================================
// write holding fifo
module lcdc_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wp_r;
	logic [PW:0]      rp_r;
	logic             push;
	logic             pop;
	logic             full;
	logic             empty;

	assign full        = (wp_r[PW] != rp_r[PW]) &&
	                     (wp_r[PW-1:0] == rp_r[PW-1:0]);
	assign empty       = (wp_r == rp_r);
	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign push        = i_in_valid && !full;
	assign pop         = i_out_ready && !empty;
	assign o_out_data  = mem[rp_r[PW-1:0]];

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wp_r[PW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_r + (PW+1)'(push);
			rp_r <= rp_r + (PW+1)'(pop);
		end
	end
endmodule

// =====================================================================
// column driver core
module lcdc_column_driver import lcdc_pkg::*; (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_select_a_n,
	input  wire logic             i_select_b_n,
	input  wire logic             i_select_c,
	input  wire logic             i_bus_strobe,
	input  wire logic             i_read_nwrite,
	input  wire logic             i_data_sel,
	input  wire logic [7:0]       i_host_data_bus,
	input  wire logic             i_column_order,
	input  wire logic             i_frame_sync,
	input  wire logic             i_line_latch_clock,
	input  wire logic             i_polarity,
	input  wire logic             i_phase_clk_1,
	input  wire logic             i_phase_clk_2,
	output logic [7:0]            o_host_data_bus,
	output logic                  o_host_data_bus_oe_n,
	output lcdc_seg_t             o_segment_outputs
);

	function automatic lcdc_level_t level_of(input logic pol,
	                                         input logic dot);
		if (pol) begin
			level_of = dot ? LVL_SEL_A : LVL_NONSEL_A;
		end else begin
			level_of = dot ? LVL_SEL_B : LVL_NONSEL_B;
		end
	endfunction

	// =================================================================
	// pin synchronisers
	lcdc_pins_t pins_raw;
	lcdc_pins_t meta_r;
	lcdc_pins_t sync_r;
	lcdc_pins_t prev_r;

	assign pins_raw = {i_select_a_n, i_select_b_n, i_select_c,
	                   i_bus_strobe, i_read_nwrite, i_data_sel,
	                   i_host_data_bus, i_column_order, i_frame_sync,
	                   i_line_latch_clock, i_polarity,
	                   i_phase_clk_1, i_phase_clk_2};

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= pins_raw;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// =================================================================
	// host access decode
	logic selected;
	logic strobe_fall;
	logic access;
	logic wr_data;
	logic wr_instr;
	logic rd_data;
	logic tick;
	logic busy;
	logic drive_nxt;
	logic fifo_in_ready;
	logic fifo_out_valid;
	lcdc_wr_t fifo_out;
	lcdc_wr_t fifo_in;
	logic [7:0] bus_in;

	assign selected    = !sync_r.host.select_a_n &&
	                     !sync_r.host.select_b_n &&
	                     sync_r.host.select_c;
	assign strobe_fall = prev_r.host.strobe && !sync_r.host.strobe;
	// every host action needs the select combination held
	assign access      = selected && strobe_fall;
	assign bus_in      = sync_r.host.data;
	// data select splits display data from control traffic
	assign wr_data     = access && !sync_r.host.read_nwrite &&
	                     sync_r.host.data_sel && fifo_in_ready;
	// instructions while busy are dropped, host must poll first
	assign wr_instr    = access && !sync_r.host.read_nwrite &&
	                     !sync_r.host.data_sel && !busy;
	assign rd_data     = access && sync_r.host.read_nwrite &&
	                     sync_r.host.data_sel;
	// internal work advances on phase-1 rise outside phase 2
	assign tick        = sync_r.phase_1 && !prev_r.phase_1 &&
	                     !sync_r.phase_2;
	assign drive_nxt   = selected && sync_r.host.read_nwrite &&
	                     sync_r.host.strobe;

	// =================================================================
	// control registers
	logic       disp_on_r;
	logic [5:0] start_line_r;
	logic [2:0] page_r;
	logic [5:0] col_r;
	logic [1:0] busy_cnt_r;
	logic [7:0] out_reg_r;
	logic [7:0] status;
	logic       is_onoff;
	logic       is_start;
	logic       is_page;
	logic       is_yaddr;

	assign is_onoff = (bus_in & OP_ONOFF_M) == OP_ONOFF;
	assign is_start = (bus_in & OP_START_M) == OP_START;
	assign is_page  = (bus_in & OP_PAGE_M) == OP_PAGE;
	assign is_yaddr = (bus_in & OP_YADDR_M) == OP_YADDR;
	// pending memory writes also count as busy
	assign busy     = (busy_cnt_r != 2'h0) || fifo_out_valid;

	always_comb begin
		status          = 8'h00;
		status[ST_BUSY] = busy;
		status[ST_OFF]  = !disp_on_r;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			disp_on_r    <= ON_RST;
			start_line_r <= START_RST;
		end else if (wr_instr && is_onoff) begin
			disp_on_r    <= bus_in[0];
		end else if (wr_instr && is_start) begin
			start_line_r <= bus_in[5:0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			page_r <= 3'h0;
			col_r  <= 6'h00;
		end else if (wr_instr && is_page) begin
			page_r <= bus_in[2:0];
		end else if (wr_instr && is_yaddr) begin
			col_r  <= bus_in[5:0];
		end else if (wr_data || rd_data) begin
			col_r  <= col_r + 6'h01;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			busy_cnt_r <= 2'h0;
		end else if (wr_instr) begin
			busy_cnt_r <= BUSY_TICKS;
		end else if (tick && busy_cnt_r != 2'h0) begin
			busy_cnt_r <= busy_cnt_r - 2'h1;
		end
	end

	// =================================================================
	// input holding fifo and display memory
	logic [7:0] ram [MEM_BYTES];

	assign fifo_in = '{addr: {page_r, col_r}, data: bus_in};

	lcdc_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk   (i_sys_clk),
		.i_rst_n     (i_rst_n),
		.i_in_valid  (wr_data),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_in),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (tick),
		.o_out_data  (fifo_out)
	);

	always_ff @(posedge i_sys_clk) begin
		if (fifo_out_valid && tick) begin
			ram[fifo_out.addr] <= fifo_out.data;
		end
	end

	// a read shows the previous fetch, then fetches the current address
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			out_reg_r <= 8'h00;
		end else if (rd_data) begin
			out_reg_r <= ram[{page_r, col_r}];
		end
	end

	// =================================================================
	// host bus drivers
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_host_data_bus      <= 8'h00;
			o_host_data_bus_oe_n <= 1'b1;
		end else begin
			o_host_data_bus      <= sync_r.host.data_sel ?
			                        out_reg_r : status;
			o_host_data_bus_oe_n <= !drive_nxt;
		end
	end

	// =================================================================
	// display refresh path
	logic [5:0]         line_r;
	logic [5:0]         line_eff;
	logic               latch_rise;
	logic               frame_rise;
	logic [NUM_SEG-1:0] line_bits;
	logic [NUM_SEG-1:0] latch_r;
	lcdc_seg_t          seg_nxt;

	assign latch_rise = sync_r.line_latch_clock &&
	                    !prev_r.line_latch_clock;
	// a long frame pulse presets once, so later lines still advance
	assign frame_rise = sync_r.frame_sync && !prev_r.frame_sync;
	// frame sync forces the start line, even on a coincident latch
	assign line_eff   = frame_rise ? start_line_r : line_r;

	for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
		localparam logic [5:0] COL_FWD = 6'(s);
		localparam logic [5:0] COL_REV = LAST_COL - 6'(s);
		logic [5:0] col;
		// column order is read live; it should be strapped
		assign col = sync_r.column_order ? COL_FWD : COL_REV;
		assign line_bits[s] = ram[{line_eff[5:3], col}][line_eff[2:0]];
		assign seg_nxt[s]   = level_of(sync_r.polarity,
		                               latch_r[s]);
	end

	// 6-bit wrap covers 1/64; shorter frames rely on frame sync
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			line_r <= 6'h00;
		end else if (latch_rise) begin
			line_r <= line_eff + 6'h01;
		end else if (frame_rise) begin
			line_r <= start_line_r;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			latch_r <= '0;
		end else if (latch_rise) begin
			latch_r <= disp_on_r ? line_bits : '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_segment_outputs <= '{default: LVL_NONSEL_B};
		end else begin
			o_segment_outputs <= seg_nxt;
		end
	end

endmodule

// *** verification/lcdc_props.sv ***
`timescale 1ns/1ps

// ======================================
// port checker
module lcdc_props import lcdc_pkg::*; (
	input  wire logic      i_sys_clk,
	input  wire logic      i_rst_n,
	input  wire logic      i_select_a_n,
	input  wire logic      i_select_b_n,
	input  wire logic      i_select_c,
	input  wire logic      i_bus_strobe,
	input  wire logic      i_read_nwrite,
	input  wire logic      i_polarity,
	input  wire logic      o_host_data_bus_oe_n,
	input  wire lcdc_seg_t o_segment_outputs
);
	logic [63:0] pol_b;
	logic [63:0] off_b;
	wire         sel = !i_select_a_n && !i_select_b_n && i_select_c;
	always_comb begin
		for (int s = 0; s < NUM_SEG; s++) begin
			pol_b[s] = o_segment_outputs[s][0];
			off_b[s] = o_segment_outputs[s][1];
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	unsel_oe_a: assert property (!sel [*5] |=> o_host_data_bus_oe_n)
		else $error("bus driven while deselected");
	write_oe_a: assert property (!i_read_nwrite [*5] |=> o_host_data_bus_oe_n)
		else $error("bus driven in write cycle");
	strobe_low_a: assert property (!i_bus_strobe [*5] |=> o_host_data_bus_oe_n)
		else $error("bus driven with strobe low");
	read_drive_a: assert property ((sel && i_read_nwrite && i_bus_strobe) [*6]
		|=> !o_host_data_bus_oe_n) else $error("read not driven");
	oe_release_a: assert property ($fell(i_bus_strobe)
		|-> ##[1:5] o_host_data_bus_oe_n) else $error("bus not released");
	pol_one_a: assert property ($rose(i_polarity) ##1 i_polarity [*4]
		|=> pol_b == '0) else $error("wrong levels for polarity one");
	pol_zero_a: assert property ($fell(i_polarity) ##1 !i_polarity [*4]
		|=> pol_b == '1) else $error("wrong levels for polarity zero");
	reset_state_a: assert property (disable iff (1'b0) !i_rst_n
		|=> o_host_data_bus_oe_n && (pol_b & off_b) == '1)
		else $error("outputs not in reset state");
	off_rst_a: assert property ($rose(i_rst_n) |-> (off_b == '1) [*8])
		else $error("dots shown after reset");

	cover property (sel && i_read_nwrite && !o_host_data_bus_oe_n);
	cover property ($rose(i_polarity));
	cover property (off_b != '1);
endmodule

bind lcdc_column_driver lcdc_props u_props (.i_sys_clk(i_sys_clk),
	.i_rst_n(i_rst_n), .i_select_a_n(i_select_a_n),
	.i_select_b_n(i_select_b_n), .i_select_c(i_select_c),
	.i_bus_strobe(i_bus_strobe), .i_read_nwrite(i_read_nwrite),
	.i_polarity(i_polarity), .o_host_data_bus_oe_n(o_host_data_bus_oe_n),
	.o_segment_outputs(o_segment_outputs));

// *** verification/lcdc_row_model.sv ***
`timescale 1ns/1ps

// ======================================
// row driver companion: phase clocks and line timing
module lcdc_row_model (
	input  wire logic i_sys_clk,
	input  wire logic i_hold,
	input  wire logic i_line_req,
	input  wire logic i_frame_req,
	output logic      o_phase_1,
	output logic      o_phase_2,
	output logic      o_line_latch_clock,
	output logic      o_frame_sync
);
	logic [3:0] ph_r = 4'h0;
	logic [3:0] ln_r = 4'h0;
	// phases never overlap, so each phase-1 rise is one tick
	assign o_phase_1          = ph_r[3:2] == 2'h0;
	assign o_phase_2          = ph_r[3:2] == 2'h2;
	assign o_line_latch_clock = ln_r[3];
	assign o_frame_sync       = ln_r[3] && i_frame_req;
	// hold freezes the ticks so the write fifo cannot drain
	always_ff @(posedge i_sys_clk) begin
		if (!i_hold)
			ph_r <= ph_r + 4'h1;
		if (i_line_req)
			ln_r <= 4'hf;
		else if (ln_r != 4'h0)
			ln_r <= ln_r - 4'h1;
	end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps

// ======================================
// bench
module testbench import lcdc_pkg::*;;
	logic clk = 1'b0, rst_n = 1'b0, cs_a_n = 1'b0, cs_b_n = 1'b0;
	logic cs_c = 1'b1, stb = 1'b0, rnw = 1'b0, ds = 1'b0, adc = 1'b1;
	logic pol = 1'b0, hold = 1'b0, lreq = 1'b0, freq = 1'b0;
	logic [7:0] dbi = 8'h00, dout, rd;
	logic       oe_n, ph1, ph2, lclk, fsync;
	lcdc_seg_t  seg;
	int         n_fail = 0;
	int         compares = 0;

	always #12.5 clk = ~clk;

	lcdc_row_model row (.i_sys_clk(clk), .i_hold(hold), .i_line_req(lreq),
		.i_frame_req(freq), .o_phase_1(ph1), .o_phase_2(ph2),
		.o_line_latch_clock(lclk), .o_frame_sync(fsync));
	lcdc_column_driver uut (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_select_a_n(cs_a_n), .i_select_b_n(cs_b_n), .i_select_c(cs_c),
		.i_bus_strobe(stb), .i_read_nwrite(rnw), .i_data_sel(ds),
		.i_host_data_bus(dbi), .i_column_order(adc), .i_frame_sync(fsync),
		.i_line_latch_clock(lclk), .i_polarity(pol), .i_phase_clk_1(ph1),
		.i_phase_clk_2(ph2), .o_host_data_bus(dout),
		.o_host_data_bus_oe_n(oe_n), .o_segment_outputs(seg));

	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chs(string nm, lcdc_level_t e, lcdc_level_t g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// strobe high and low six clocks each, fields held across the fall
	task automatic cyc(logic d, logic r, logic [7:0] w);
		@(posedge clk);
		ds <= d;
		rnw <= r;
		dbi <= w;
		repeat (4) @(posedge clk);
		stb <= 1'b1;
		repeat (6) @(posedge clk);
		rd = dout;
		stb <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic ins(logic [7:0] w);
		int n;
		n = 0;
		do begin
			cyc(1'b0, 1'b1, 8'h00);
			n++;
		end while (rd[7] !== 1'b0 && n < 50);
		chk("busy_poll", 8'h00, rd & 8'h80);
		cyc(1'b0, 1'b0, w);
	endtask
	task automatic rdc(string nm, logic [7:0] e);
		cyc(1'b1, 1'b1, 8'h00);
		chk(nm, e, rd);
	endtask
	task automatic line(logic f);
		freq <= f;
		lreq <= 1'b1;
		@(posedge clk);
		lreq <= 1'b0;
		repeat (12) @(posedge clk);
	endtask

	task automatic t_reset;
		chs("seg0", LVL_NONSEL_B, seg[0]);
		cyc(1'b0, 1'b1, 8'h00);
		chk("status", 8'h20, rd);
		$display("t_reset done");
	endtask
	task automatic t_show;
		ins(8'hb8);
		ins(8'h40);
		cyc(1'b1, 1'b0, 8'h01);
		cyc(1'b1, 1'b0, 8'h02);
		ins(8'h3f);
		pol <= 1'b1;
		line(1'b1);
		chs("l0s0", LVL_SEL_A, seg[0]);
		chs("l0s1", LVL_NONSEL_A, seg[1]);
		pol <= 1'b0;
		line(1'b0);
		chs("l1s1", LVL_SEL_B, seg[1]);
		chs("l1s0", LVL_NONSEL_B, seg[0]);
		adc <= 1'b0;
		line(1'b1);
		chs("rev", LVL_SEL_B, seg[63]);
		adc <= 1'b1;
		$display("t_show done");
	endtask
	task automatic t_read;
		ins(8'h40);
		cyc(1'b1, 1'b1, 8'h00);
		rdc("col0", 8'h01);
		rdc("col1", 8'h02);
		ins(8'h7f);
		cyc(1'b1, 1'b0, 8'haa);
		cyc(1'b1, 1'b0, 8'h55);
		ins(8'h7f);
		cyc(1'b1, 1'b1, 8'h00);
		rdc("col63", 8'haa);
		rdc("wrap", 8'h55);
		$display("t_read done");
	endtask
	task automatic t_unsel;
		ins(8'h41);
		cs_a_n <= 1'b1;
		cyc(1'b0, 1'b0, 8'h3e);
		cs_a_n <= 1'b0;
		cs_b_n <= 1'b1;
		cyc(1'b0, 1'b0, 8'hc1);
		cs_b_n <= 1'b0;
		cs_c <= 1'b0;
		cyc(1'b1, 1'b0, 8'hff);
		cs_c <= 1'b1;
		line(1'b1);
		chs("unsel", LVL_SEL_B, seg[0]);
		ins(8'h41);
		cyc(1'b1, 1'b1, 8'h00);
		rdc("keep", 8'h02);
		$display("t_unsel done");
	endtask
	task automatic t_fifo;
		ins(8'hb9);
		ins(8'h40);
		hold <= 1'b1;
		for (logic [7:0] k = 8'h00; k < 8'h0a; k++)
			cyc(1'b1, 1'b0, 8'h10 + k);
		cyc(1'b0, 1'b1, 8'h00);
		chk("busy", 8'h80, rd);
		hold <= 1'b0;
		ins(8'h3f);
		cyc(1'b1, 1'b0, 8'h77);
		ins(8'h40);
		cyc(1'b1, 1'b1, 8'h00);
		for (logic [7:0] k = 8'h00; k < 8'h08; k++)
			rdc("fifo", 8'h10 + k);
		rdc("drop", 8'h77);
		$display("t_fifo done");
	endtask

	task automatic summarize;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_reset;
		t_show;
		t_read;
		t_unsel;
		t_fifo;
		summarize;
	end
	// the run needs under two thousand clocks; cut it at forty thousand
	initial begin
		#1000000;
		n_fail++;
		summarize;
	end
endmodule
